// ### bench/itp_props.sv
`timescale 1ns/100ps
`default_nettype none

module itp_props
(
  input wire logic clock,
  input wire logic rst,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic hst_scl_o,
  input wire logic hst_scl_oe,
  input wire logic hst_sda_o,
  input wire logic hst_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  dev_low_only_a: assert property (dev_scl_oe || dev_sda_oe |-> !dev_scl_o && !dev_sda_o)
    else $error("device drives a line high");
  hst_low_only_a: assert property (hst_scl_oe || hst_sda_oe |-> !hst_scl_o && !hst_sda_o)
    else $error("host drives a line high");
  scl_wired_a: assert property (scl == !(dev_scl_oe || hst_scl_oe))
    else $error("clock line level not set by its pullers");
  sda_wired_a: assert property (sda == !(dev_sda_oe || hst_sda_oe))
    else $error("data line level not set by its pullers");
  // one host cycle is far below any legal phase, so 8 is a safe floor
  scl_high_min_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  scl_low_min_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  start_hold_a: assert property ($fell(sda) && scl && $past(scl) |-> scl [*4])
    else $error("clock left high too briefly after start");
  stop_idle_a: assert property ($rose(sda) && scl && $past(scl) |=> !hst_scl_oe && !dev_scl_oe)
    else $error("clock pulled after stop");

  cover property ($fell(sda) && scl);
  cover property ($rose(dev_scl_oe));
  cover property ($rose(dev_sda_oe) && scl);
endmodule : itp_props

`default_nettype wire

// ### bench/tb_i2c_target_with_proxy_master_timing.sv
`timescale 1ns/100ps
`default_nettype none

module tb_i2c_target_with_proxy_master_timing
  import itp_pkg::*;
;
  logic clock = 1'b0;
  logic ref_clk = 1'b1;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] strap = 2'h1;
  logic px_go = 1'b0;
  logic px_read = 1'b0;
  logic [6:0] px_addr = 7'h2a;
  logic [7:0] px_wdata = 8'h5a;
  logic [31:0] rdata;
  logic [31:0] st;
  logic pin_o, pin_oe, pin_was, cfg_done, io_3v3, px_busy, px_done, px_nack;
  logic [6:0] dev_addr;
  logic [7:0] hi_cnt, lo_cnt, px_rdata;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  // every edge of the reference clock lands on an edge of clock
  always #5 clock = ~clock;
  always #15 ref_clk = ~ref_clk;

  itp_bus_if i_itp_bus_if ();
  itp_device i_itp_device (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .bus(i_itp_bus_if.dev),
    .address_strap_pin_level(strap), .address_strap_pin_o(pin_o), .address_strap_pin_oe(pin_oe),
    .cfg_done(cfg_done), .io_is_3v3(io_3v3), .dev_addr(dev_addr), .px_go(px_go),
    .px_read(px_read), .px_addr(px_addr), .px_wdata(px_wdata), .px_busy(px_busy),
    .px_done(px_done), .px_nack(px_nack), .px_rdata(px_rdata), .scl_high_count(hi_cnt),
    .scl_low_count(lo_cnt));
  itp_host i_itp_host (.clock(clock), .rst(rst), .ce(1'b1), .bus(i_itp_bus_if.hst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  itp_props i_itp_props (.clock(clock), .rst(rst), .dev_scl_o(i_itp_bus_if.dev_scl_o),
    .dev_scl_oe(i_itp_bus_if.dev_scl_oe), .dev_sda_o(i_itp_bus_if.dev_sda_o),
    .dev_sda_oe(i_itp_bus_if.dev_sda_oe), .hst_scl_o(i_itp_bus_if.hst_scl_o),
    .hst_scl_oe(i_itp_bus_if.hst_scl_oe), .hst_sda_o(i_itp_bus_if.hst_sda_o),
    .hst_sda_oe(i_itp_bus_if.hst_sda_oe), .scl(i_itp_bus_if.scl), .sda(i_itp_bus_if.sda));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask : chk

  task automatic hw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : hw

  task automatic hr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : hr

  // poll busy, bounded so a stuck engine cannot hang the run
  task automatic run(input logic [31:0] ctrl);
    int n;
    hw(ITP_H_CTRL, ctrl);
    n = 0;
    hr(ITP_H_STATUS, st);
    while (st[ITP_STAT_BUSY] !== 1'b0 && n < 9000)
    begin
      hr(ITP_H_STATUS, st);
      n++;
    end
    chk("idle", 32'(st[ITP_STAT_BUSY]), 32'h0);
  endtask : run

  task automatic dev_wr(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] v);
    hw(ITP_H_TX, {16'h0, v, ptr});
    run({17'h0, a, 8'h05});
  endtask : dev_wr

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_strap;
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i + 2);
      strap <= c;
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (40) @(posedge clock);
      chk("addr", 32'(dev_addr), 32'(c[0] ? ITP_ADDR_HI : ITP_ADDR_LO));
      chk("io", 32'(io_3v3), 32'(c[1]));
      chk("pin", 32'({cfg_done, pin_oe}), 32'h3);
    end
    // once configured the pin must toggle on every rising reference edge
    @(negedge ref_clk);
    pin_was = pin_o;
    @(negedge ref_clk);
    chk("clkout", 32'(pin_o), 32'(!pin_was));
    chk("regs", 32'({hi_cnt, lo_cnt}), 32'({ITP_SCL_HIGH_RST, ITP_SCL_LOW_RST}));
    hr(ITP_H_DIV, st);
    chk("div", st, 32'(ITP_DIV_RST));
    hr(4'h2, st);
    chk("unmapped", st, 32'h0);
    $display("done strap");
  endtask : t_strap

  task automatic t_write;
    dev_wr(ITP_ADDR_HI, ITP_REG_SCL_HIGH, 8'h06);
    chk("ack", 32'(st[ITP_STAT_NACK]), 32'h0);
    dev_wr(ITP_ADDR_HI, ITP_REG_SCL_LOW, 8'h0b);
    chk("regs", 32'({hi_cnt, lo_cnt}), 32'h060b);
    dev_wr(ITP_ADDR_LO, ITP_REG_SCL_HIGH, 8'h13);
    chk("nack", 32'(st[ITP_STAT_NACK]), 32'h1);
    chk("kept", 32'(hi_cnt), 32'h06);
    $display("done write");
  endtask : t_write

  task automatic t_read;
    hw(ITP_H_TX, 32'(ITP_REG_SCL_LOW));
    run({17'h0, ITP_ADDR_HI, 8'h01});
    run({17'h0, ITP_ADDR_HI, 8'h03});
    chk("rx", 32'(st[15:8]), 32'h0b);
    chk("rxack", 32'(st[ITP_STAT_NACK]), 32'h0);
    hr(ITP_H_CTRL, st);
    chk("ctrl", st, 32'h00001902);
    $display("done read");
  endtask : t_read

  // nobody answers 0x2a, so the proxy must stop after the address
  task automatic t_proxy;
    int n;
    @(posedge ref_clk);
    px_go <= 1'b1;
    @(posedge ref_clk);
    px_go <= 1'b0;
    @(negedge i_itp_bus_if.scl);
    n = 0;
    while (i_itp_bus_if.scl !== 1'b1 && n < 900)
    begin
      @(posedge clock);
      n++;
    end
    chk("low", 32'(n >= 48 && n < 900), 32'h1);
    n = 0;
    while (i_itp_bus_if.scl === 1'b1 && n < 900)
    begin
      @(posedge clock);
      n++;
    end
    chk("high", 32'(n >= 33 && n < 900), 32'h1);
    chk("pbusy", 32'(px_busy), 32'h1);
    n = 0;
    while (px_done !== 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("pnack", 32'({px_done, px_busy, px_nack}), 32'h5);
    $display("done proxy");
  endtask : t_proxy

  // the proxy reads the device's own target back over the shared lines
  task automatic t_proxy_rd;
    int n;
    // let the proxy's stop reach the target before the host starts
    repeat (20) @(posedge clock);
    hw(ITP_H_TX, 32'(ITP_REG_SCL_HIGH));
    run({17'h0, ITP_ADDR_HI, 8'h01});
    @(posedge ref_clk);
    px_read <= 1'b1;
    px_addr <= ITP_ADDR_HI;
    px_go <= 1'b1;
    @(posedge ref_clk);
    px_go <= 1'b0;
    n = 0;
    while (px_done !== 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("pread", 32'({px_done, px_busy, px_nack, px_rdata}), 32'h406);
    $display("done proxy read");
  endtask : t_proxy_rd

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_strap;
    hw(ITP_H_DIV, 32'h14);
    t_write;
    t_read;
    t_proxy;
    t_proxy_rd;
    end_of_test;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      end_of_test;
    end
  end
endmodule : tb_i2c_target_with_proxy_master_timing

`default_nettype wire

// ### src/itp_bus_if.sv
`timescale 1ns/100ps
`default_nettype none

interface itp_bus_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic hst_scl_o;
  logic hst_scl_oe;
  logic hst_sda_o;
  logic hst_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-up: a line is low only while someone drives it low
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (hst_scl_oe & ~hst_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (hst_sda_oe & ~hst_sda_o));

  modport dev (
    input scl,
    input sda,
    output dev_scl_o,
    output dev_scl_oe,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport hst (
    input scl,
    input sda,
    output hst_scl_o,
    output hst_scl_oe,
    output hst_sda_o,
    output hst_sda_oe
  );
endinterface : itp_bus_if

`default_nettype wire

// ### src/itp_device.sv
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module itp_device
  import itp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  itp_bus_if.dev bus,
  input wire logic [1:0] address_strap_pin_level,
  output logic address_strap_pin_o,
  output logic address_strap_pin_oe,
  output logic cfg_done,
  output logic io_is_3v3,
  output logic [6:0] dev_addr,
  input wire logic px_go,
  input wire logic px_read,
  input wire logic [6:0] px_addr,
  input wire logic [7:0] px_wdata,
  output logic px_busy,
  output logic px_done,
  output logic px_nack,
  output logic [7:0] px_rdata,
  output logic [7:0] scl_high_count,
  output logic [7:0] scl_low_count
);

  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK, T_WR, T_RD, T_RACK} itp_tgt_t;
  typedef enum logic [2:0] {P_IDLE, P_START, P_LOW, P_RISE, P_HIGH} itp_px_t;

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [1:0] strap_m, strap_s;
  logic [2:0] settle_r;
  itp_tgt_t t_st;
  logic [3:0] t_bcnt;
  logic [7:0] t_sh, t_ptr;
  logic t_rw, t_first, t_more, t_sda_oe, t_scl_oe;
  logic [8:0] t_cnt;
  itp_px_t p_st;
  logic [3:0] p_bcnt;
  logic [7:0] p_sh;
  logic p_byte, p_rd, p_stop, p_sda_oe, p_scl_oe;
  logic [8:0] p_cnt;
  logic scl_oe_r, sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus line synchronisers and condition detect
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (ce)
    begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire [8:0] low5 = {1'b0, scl_low_count} + ITP_SYNC_EXTRA;
  wire [8:0] high5 = {1'b0, scl_high_count} + ITP_SYNC_EXTRA;
  wire [8:0] half5 = {1'b0, low5[8:1]};

  ////////////////////////////////////////////////////////////////////////////
  // strap capture, then the pin turns into the sensor clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_m <= 2'h0;
      strap_s <= 2'h0;
      settle_r <= 3'h0;
      cfg_done <= 1'b0;
      dev_addr <= ITP_ADDR_LO;
      io_is_3v3 <= 1'b0;
    end
    else if (ce && !cfg_done)
    begin
      strap_m <= address_strap_pin_level;
      strap_s <= strap_m;
      settle_r <= settle_r + 3'h1;
      if (settle_r == ITP_STRAP_SETTLE)
      begin
        cfg_done <= 1'b1;
        // settings 1/3 and 2/4 share an address, differ in io level
        dev_addr <= strap_s[ITP_STRAP_SET_BIT] ? ITP_ADDR_HI : ITP_ADDR_LO;
        io_is_3v3 <= strap_s[ITP_STRAP_IO_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      address_strap_pin_o <= 1'b0;
      address_strap_pin_oe <= 1'b0;
    end
    else if (ce)
    begin
      address_strap_pin_oe <= cfg_done;
      address_strap_pin_o <= cfg_done & ~address_strap_pin_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing registers, written through the target
  wire [7:0] rd_byte = (t_ptr == ITP_REG_SCL_HIGH) ? scl_high_count :
                       (t_ptr == ITP_REG_SCL_LOW) ? scl_low_count : 8'h00;
  wire reg_wr = ce & ~start_det & ~stop_det & (t_st == T_WR) & scl_fall &
                (t_bcnt == 4'h8) & ~t_first;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_high_count <= ITP_SCL_HIGH_RST;
      scl_low_count <= ITP_SCL_LOW_RST;
    end
    else if (reg_wr && t_ptr == ITP_REG_SCL_HIGH)
      scl_high_count <= t_sh;
    else if (reg_wr && t_ptr == ITP_REG_SCL_LOW)
      scl_low_count <= t_sh;
  end

  ////////////////////////////////////////////////////////////////////////////
  // target: first write byte is the pointer, pointer advances per byte
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      t_st <= T_IDLE;
      t_bcnt <= 4'h0;
      t_sh <= 8'h00;
      t_ptr <= 8'h00;
      t_rw <= 1'b0;
      t_first <= 1'b0;
      t_more <= 1'b0;
      t_sda_oe <= 1'b0;
      t_scl_oe <= 1'b0;
      t_cnt <= 9'h000;
    end
    else if (ce)
    begin
      if (start_det)
      begin
        t_st <= T_ADDR;
        t_bcnt <= 4'h0;
        t_first <= 1'b1;
        t_sda_oe <= 1'b0;
        t_scl_oe <= 1'b0;
      end
      else if (stop_det)
      begin
        t_st <= T_IDLE;
        t_sda_oe <= 1'b0;
        t_scl_oe <= 1'b0;
      end
      else
        case (t_st)
          T_ADDR:
            if (scl_rise)
            begin
              t_sh <= {t_sh[6:0], sda_s};
              t_bcnt <= t_bcnt + 4'h1;
            end
            else if (scl_fall && t_bcnt == 4'h8)
            begin
              if (cfg_done && t_sh[7:1] == dev_addr)
              begin
                t_rw <= t_sh[0];
                t_sda_oe <= 1'b1;
                t_st <= T_ACK;
              end
              else
                t_st <= T_IDLE;
            end
          T_ACK:
            if (scl_fall)
            begin
              t_bcnt <= 4'h0;
              if (t_rw)
              begin
                t_sh <= rd_byte;
                t_sda_oe <= ~rd_byte[7];
                t_scl_oe <= 1'b1;
                t_cnt <= low5;
                t_st <= T_RD;
              end
              else
              begin
                t_sda_oe <= 1'b0;
                t_st <= T_WR;
              end
            end
          T_WR:
            if (scl_rise)
            begin
              t_sh <= {t_sh[6:0], sda_s};
              t_bcnt <= t_bcnt + 4'h1;
            end
            else if (scl_fall && t_bcnt == 4'h8)
            begin
              t_sda_oe <= 1'b1;
              t_ptr <= t_first ? t_sh : t_ptr + 8'h01;
              t_first <= 1'b0;
              t_st <= T_ACK;
            end
          T_RD:
            if (t_scl_oe)
            begin
              // data already on sda; hold scl until the setup count runs out
              if (t_cnt == 9'h000)
                t_scl_oe <= 1'b0;
              else
                t_cnt <= t_cnt - 9'h001;
            end
            else if (scl_rise)
              t_bcnt <= t_bcnt + 4'h1;
            else if (scl_fall && t_bcnt == 4'h8)
            begin
              t_sda_oe <= 1'b0;
              t_st <= T_RACK;
            end
            else if (scl_fall)
            begin
              t_sh <= {t_sh[6:0], 1'b0};
              t_sda_oe <= ~t_sh[6];
              t_scl_oe <= 1'b1;
              t_cnt <= low5;
            end
          T_RACK:
            if (scl_rise)
            begin
              t_more <= ~sda_s;
              t_ptr <= t_ptr + 8'h01;
            end
            else if (scl_fall && t_more)
            begin
              t_bcnt <= 4'h0;
              t_sh <= rd_byte;
              t_sda_oe <= ~rd_byte[7];
              t_scl_oe <= 1'b1;
              t_cnt <= low5;
              t_st <= T_RD;
            end
            else if (scl_fall)
              t_st <= T_IDLE;
          default:
            t_st <= T_IDLE;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // proxy master: start, address byte, one data byte, stop
  // bus must be idle when px_go arrives; there is no arbitration
  wire p_rx = p_byte & p_rd;
  wire p_drive = p_stop | ((p_bcnt != 4'h8) & ~p_rx & ~p_sh[7]);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      p_st <= P_IDLE;
      p_bcnt <= 4'h0;
      p_sh <= 8'h00;
      p_byte <= 1'b0;
      p_rd <= 1'b0;
      p_stop <= 1'b0;
      p_sda_oe <= 1'b0;
      p_scl_oe <= 1'b0;
      p_cnt <= 9'h000;
      px_busy <= 1'b0;
      px_done <= 1'b0;
      px_nack <= 1'b0;
      px_rdata <= 8'h00;
    end
    else if (ce)
    begin
      px_done <= 1'b0;
      case (p_st)
        P_IDLE:
          if (px_go)
          begin
            p_sh <= {px_addr, px_read};
            p_rd <= px_read;
            p_byte <= 1'b0;
            p_stop <= 1'b0;
            p_bcnt <= 4'h0;
            p_sda_oe <= 1'b1;
            p_cnt <= high5;
            px_busy <= 1'b1;
            px_nack <= 1'b0;
            p_st <= P_START;
          end
        P_START:
          if (p_cnt == 9'h000)
          begin
            p_scl_oe <= 1'b1;
            p_cnt <= low5;
            p_st <= P_LOW;
          end
          else
            p_cnt <= p_cnt - 9'h001;
        P_LOW:
          begin
            // sda moves mid-low so it never changes beside an scl edge
            if (p_cnt == half5)
              p_sda_oe <= p_drive;
            if (p_cnt == 9'h000)
            begin
              p_scl_oe <= 1'b0;
              p_st <= P_RISE;
            end
            else
              p_cnt <= p_cnt - 9'h001;
          end
        P_RISE:
          if (scl_s)
          begin
            p_cnt <= high5;
            p_st <= P_HIGH;
          end
        P_HIGH:
          if (p_cnt != 9'h000)
            p_cnt <= p_cnt - 9'h001;
          else if (p_stop)
          begin
            p_sda_oe <= 1'b0;
            px_busy <= 1'b0;
            px_done <= 1'b1;
            p_st <= P_IDLE;
          end
          else
          begin
            p_scl_oe <= 1'b1;
            p_cnt <= low5;
            p_st <= P_LOW;
            if (p_bcnt != 4'h8)
            begin
              p_sh <= {p_sh[6:0], sda_s};
              p_bcnt <= p_bcnt + 4'h1;
            end
            else
            begin
              p_bcnt <= 4'h0;
              if (p_rx)
                px_rdata <= p_sh;
              if (!p_rx && sda_s)
                px_nack <= 1'b1;
              p_stop <= p_byte | (~p_rx & sda_s);
              p_byte <= 1'b1;
              p_sh <= p_rd ? 8'hff : px_wdata;
            end
          end
        default:
          p_st <= P_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pins: output level is always low, only enables move
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (ce)
    begin
      scl_oe_r <= t_scl_oe | p_scl_oe;
      sda_oe_r <= t_sda_oe | p_sda_oe;
    end
  end

  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe = scl_oe_r;
  assign bus.dev_sda_oe = sda_oe_r;

endmodule : itp_device

`default_nettype wire

// ### src/itp_host.sv
`timescale 1ns/100ps
`default_nettype none

module itp_host
  import itp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  itp_bus_if.hst bus,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_RISE, H_HIGH} itp_hst_t;

  logic scl_m, scl_s, sda_m, sda_s;
  itp_hst_t h_st;
  logic [3:0] h_bcnt;
  logic [7:0] h_sh, rx_r;
  logic [1:0] h_byte;
  logic h_stop, h_rd, h_two, busy_r, nack_r, scl_oe_r, sda_oe_r;
  logic [6:0] addr_r;
  logic [15:0] tx_r, div_r, h_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  wire go = ce & wr & (addr == ITP_H_CTRL) & wdata[ITP_CTRL_GO] & ~busy_r;
  wire h_rx = (h_byte != 2'h0) & h_rd;
  wire h_last = h_rd ? (h_byte == 2'h1) : (h_byte == {h_two, ~h_two});
  wire h_drive = h_stop | ((h_bcnt != 4'h8) & ~h_rx & ~h_sh[7]);
  wire [7:0] h_next = h_rd ? 8'hff : ((h_byte == 2'h0) ? tx_r[7:0] : tx_r[15:8]);
  wire [15:0] h_half = {1'b0, div_r[15:1]};
  wire [31:0] stat_word = {16'h0000, rx_r, 6'h00, nack_r, busy_r};
  wire [31:0] rd_mux = (addr == ITP_H_CTRL) ? {17'h00000, addr_r, 5'h00, h_two, h_rd, 1'b0} :
                       (addr == ITP_H_TX) ? {16'h0000, tx_r} :
                       (addr == ITP_H_STATUS) ? stat_word :
                       (addr == ITP_H_DIV) ? {16'h0000, div_r} : 32'h00000000;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 32'h00000000;
      tx_r <= 16'h0000;
      div_r <= ITP_DIV_RST;
    end
    else if (ce)
    begin
      rdata <= rd ? rd_mux : 32'h00000000;
      if (wr && addr == ITP_H_TX)
        tx_r <= wdata[15:0];
      // a zero divider would stall nothing but make no valid timing
      if (wr && addr == ITP_H_DIV && !busy_r)
        div_r <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the device lives on another clock: two flops per line
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end
    else if (ce)
    begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master sequencer; scl waits for the line itself so stretching is honoured
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      h_st <= H_IDLE;
      h_bcnt <= 4'h0;
      h_sh <= 8'h00;
      h_byte <= 2'h0;
      h_stop <= 1'b0;
      h_rd <= 1'b0;
      h_two <= 1'b0;
      addr_r <= 7'h00;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      rx_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      h_cnt <= 16'h0000;
    end
    else if (ce)
      case (h_st)
        H_IDLE:
          if (go)
          begin
            h_rd <= wdata[ITP_CTRL_RD];
            h_two <= wdata[ITP_CTRL_TWO];
            addr_r <= wdata[ITP_CTRL_ADDR +: 7];
            h_sh <= {wdata[ITP_CTRL_ADDR +: 7], wdata[ITP_CTRL_RD]};
            h_byte <= 2'h0;
            h_bcnt <= 4'h0;
            h_stop <= 1'b0;
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b1;
            h_cnt <= div_r;
            h_st <= H_START;
          end
        H_START:
          if (h_cnt == 16'h0000)
          begin
            scl_oe_r <= 1'b1;
            h_cnt <= div_r;
            h_st <= H_LOW;
          end
          else
            h_cnt <= h_cnt - 16'h0001;
        H_LOW:
          begin
            if (h_cnt == h_half)
              sda_oe_r <= h_drive;
            if (h_cnt == 16'h0000)
            begin
              scl_oe_r <= 1'b0;
              h_st <= H_RISE;
            end
            else
              h_cnt <= h_cnt - 16'h0001;
          end
        H_RISE:
          if (scl_s)
          begin
            h_cnt <= div_r;
            h_st <= H_HIGH;
          end
        H_HIGH:
          if (h_cnt != 16'h0000)
            h_cnt <= h_cnt - 16'h0001;
          else if (h_stop)
          begin
            sda_oe_r <= 1'b0;
            busy_r <= 1'b0;
            h_st <= H_IDLE;
          end
          else
          begin
            scl_oe_r <= 1'b1;
            h_cnt <= div_r;
            h_st <= H_LOW;
            if (h_bcnt != 4'h8)
            begin
              h_sh <= {h_sh[6:0], sda_s};
              h_bcnt <= h_bcnt + 4'h1;
            end
            else
            begin
              h_bcnt <= 4'h0;
              if (h_rx)
                rx_r <= h_sh;
              if (!h_rx && sda_s)
                nack_r <= 1'b1;
              h_stop <= h_last | (~h_rx & sda_s);
              h_byte <= h_byte + 2'h1;
              h_sh <= h_next;
            end
          end
        default:
          h_st <= H_IDLE;
      endcase
  end

  assign bus.hst_scl_o = 1'b0;
  assign bus.hst_sda_o = 1'b0;
  assign bus.hst_scl_oe = scl_oe_r;
  assign bus.hst_sda_oe = sda_oe_r;

endmodule : itp_host

`default_nettype wire

// ### src/itp_pkg.sv
package itp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // target addresses and timing registers on the shared bus
  localparam logic [6:0] ITP_ADDR_LO = 7'h18;
  localparam logic [6:0] ITP_ADDR_HI = 7'h19;
  localparam logic [7:0] ITP_REG_SCL_HIGH = 8'h0b;
  localparam logic [7:0] ITP_REG_SCL_LOW = 8'h0c;
  // 38.1 ns x (127 + 5) covers 5 us at 26.25 MHz
  localparam logic [7:0] ITP_SCL_HIGH_RST = 8'h7f;
  localparam logic [7:0] ITP_SCL_LOW_RST = 8'h7f;
  localparam logic [8:0] ITP_SYNC_EXTRA = 9'h005;
  // reference cycles after reset before the strap is latched
  localparam logic [2:0] ITP_STRAP_SETTLE = 3'h4;
  localparam int ITP_STRAP_SET_BIT = 0;
  localparam int ITP_STRAP_IO_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // host command registers
  localparam logic [3:0] ITP_H_CTRL = 4'h0;
  localparam logic [3:0] ITP_H_TX = 4'h4;
  localparam logic [3:0] ITP_H_STATUS = 4'h8;
  localparam logic [3:0] ITP_H_DIV = 4'hc;
  localparam int ITP_CTRL_GO = 0;
  localparam int ITP_CTRL_RD = 1;
  localparam int ITP_CTRL_TWO = 2;
  localparam int ITP_CTRL_ADDR = 8;
  localparam int ITP_STAT_BUSY = 0;
  localparam int ITP_STAT_NACK = 1;
  localparam int ITP_STAT_RX = 8;
  localparam int ITP_CLOCK_NS = 10;
  localparam int ITP_HOST_PHASE_NS = 5000;
  localparam logic [15:0] ITP_DIV_RST =
    16'((ITP_HOST_PHASE_NS + ITP_CLOCK_NS - 1) / ITP_CLOCK_NS);

endpackage : itp_pkg
